/* File: design/fpm_flash_core.sv */
// Flash array with timed page program and whole-array erase
`timescale 1ns/1ps
module fpm_flash_core import fpm_pkg::*; #(
  parameter int unsigned WRITE_CYC_P = WRITE_CYC,
  parameter int unsigned ERASE_CYC_P = ERASE_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                start_pgm,
  input  wire logic                start_ers,
  input  wire logic [PG_NUM_W-1:0] pg,
  input  wire logic [7:0]          buf_data,
  output logic      [PAGE_W-1:0]   buf_idx,
  input  wire logic [ADDR_W-1:0]   rd_addr,
  output logic      [7:0]          rd_data,
  output logic                     pg_used,
  output logic                     busy,
  output logic                     done
);
  typedef enum logic [4:0] {
    C_IDLE = 5'b00001, C_PWAIT = 5'b00010, C_PCOPY = 5'b00100,
    C_EWAIT = 5'b01000, C_ESWEEP = 5'b10000
  } fpm_cop_e;
  typedef struct packed {
    fpm_cop_e            op;
    logic [31:0]         cnt;
    logic [ADDR_W-1:0]   idx;
    logic [PG_NUM_W-1:0] pg;
    logic                done;
  } fpm_core_s;

  fpm_core_s s, next_s;
  logic [7:0] mem  [2**ADDR_W];
  logic       used [2**PG_NUM_W];
  logic       mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]  mem_wd;

  // Sequencer: wait the cell time, then copy or sweep
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    mem_we = 1'b0;
    mem_wa = s.idx;
    mem_wd = FILL_BYTE;
    unique case (s.op)
      C_IDLE: begin
        next_s.cnt = '0;
        next_s.idx = '0;
        if (start_pgm) begin
          next_s.op = C_PWAIT;
          next_s.pg = pg;
        end else if (start_ers) begin
          next_s.op = C_EWAIT;
        end
      end
      C_PWAIT: begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt == WRITE_CYC_P - 1) begin
          next_s.op = C_PCOPY;
        end
      end
      C_PCOPY: begin
        mem_we = 1'b1;
        mem_wa = {s.pg, s.idx[PAGE_W-1:0]};
        mem_wd = buf_data;
        next_s.idx = s.idx + 1'b1;
        if (s.idx[PAGE_W-1:0] == PAGE_W'(PAGE_BYTES - 1)) begin
          next_s.op = C_IDLE;
          next_s.done = 1'b1;
        end
      end
      C_EWAIT: begin
        next_s.cnt = s.cnt + 32'h1;
        if (s.cnt == ERASE_CYC_P - 1) begin
          next_s.op = C_ESWEEP;
        end
      end
      C_ESWEEP: begin
        mem_we = 1'b1; // Whole array, every address RULE_10
        next_s.idx = s.idx + 1'b1;
        if (&s.idx) begin
          next_s.op = C_IDLE;
          next_s.done = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{op: C_IDLE, cnt: '0, idx: '0, pg: '0, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Cell array and per-page programmed marks
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (s.op == C_PCOPY) begin
      used[s.pg] <= 1'b1;
    end else if (s.op == C_ESWEEP && s.idx[PAGE_W-1:0] == '0) begin
      used[s.idx[ADDR_W-1:PAGE_W]] <= 1'b0;
    end
  end

  assign buf_idx = s.idx[PAGE_W-1:0];
  assign rd_data = mem[rd_addr];
  assign pg_used = used[pg] === 1'b1;
  assign busy    = s.op != C_IDLE;
  assign done    = s.done;
endmodule // fpm_flash_core

/* File: design/fpm_page_buf.sv */
// Page staging buffer holding the bytes of one auto-program page
`timescale 1ns/1ps
module fpm_page_buf import fpm_pkg::*; #(
  parameter int DEPTH = PAGE_BYTES,
  parameter int W     = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [W-1:0]             rd_data
);
  logic [W-1:0] mem [DEPTH];

  // Byte store, no reset needed on data
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem[rd_idx];
endmodule // fpm_page_buf

/* File: design/fpm_pkg.sv */
// Shared constants, types and pin carrier for the programmer-mode flash port
package fpm_pkg;
  localparam int ADDR_W   = 15;
  localparam int PAGE_W   = 7;
  localparam int PAGE_BYTES = 128;
  localparam int PG_NUM_W = ADDR_W - PAGE_W;

  // Command bytes of the first bus write cycle
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_PGM  = 8'h40;
  localparam logic [7:0] CMD_ERS  = 8'h20;
  localparam logic [7:0] CMD_STS  = 8'h71;
  localparam logic [7:0] FILL_BYTE = 8'hff;

  // Return code bit positions
  localparam int RC_ABN  = 7;
  localparam int RC_CMD  = 6;
  localparam int RC_PGM  = 5;
  localparam int RC_ERS  = 4;
  localparam int RC_OVER = 1;
  localparam int RC_ADDR = 0;
  localparam logic [7:0] RC_RESET = 8'h00;

  // Polling pair {data_pin_seven, data_pin_six}
  localparam logic [1:0] POLL_BUSY = 2'b00;
  localparam logic [1:0] POLL_ABN  = 2'b10;
  localparam logic [1:0] POLL_OK   = 2'b11;

  // APB register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_LOCK = 0;
  localparam logic CTRL_LOCK_RST = 1'b0;
  localparam int STAT_POLL = 8;
  localparam int STAT_BUSY = 10;
  localparam int STAT_ST   = 16;

  // Timing
  localparam int CLK_HZ     = 40_000_000;
  localparam int T_WRITE_MS = 1;
  localparam int T_ERASE_MS = 100;
  localparam int WRITE_CYC  = T_WRITE_MS * (CLK_HZ / 1000);
  localparam int ERASE_CYC  = T_ERASE_MS * (CLK_HZ / 1000);

  // Programmer pins sampled by the device
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fpm_pin_in_s;
endpackage

/* File: design/fpm_port.sv */
// Programmer-mode command port: pin sequencer, status, APB control
//
// What this block does
// RULE_01 - Auto-program writes one 128-byte page
// RULE_02 - Short pages padded with FF by programmer
// RULE_03 - Page address low 7 bits zero
// RULE_04 - Bad page address still writes, flags error
// RULE_05 - Address taken only in second cycle
// RULE_06 - No command writes while programming
// RULE_07 - Each page programmed once between erases
// RULE_08 - Program completion shown on data_pin_six
// RULE_09 - Polling pins held until next command
// RULE_10 - Auto-erase always clears whole array
// RULE_11 - No command writes while erasing
// RULE_12 - Programmer waits 1 ms before polling
// RULE_13 - Programmer waits 20 us before code read
// RULE_14 - Status read mode reports failure cause
// RULE_15 - Return code held until non-status command
// RULE_16 - Return code bit meanings, reset zero
// RULE_17 - Command bytes 00, 40, 20x2, 71x2
// RULE_18 - Program sequence is 129 write cycles
// RULE_19 - Polling: pin7 low busy, pin6 ok
// RULE_20 - Power-on enters memory read mode
// RULE_21 - Drive data pins only with CE, OE
`timescale 1ns/1ps
module fpm_port import fpm_pkg::*; #(
  parameter int unsigned WRITE_CYC_P = WRITE_CYC,
  parameter int unsigned ERASE_CYC_P = ERASE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire fpm_pin_in_s pin_in,
  output logic      [7:0]  data_out,
  output logic             data_oe
);
  typedef enum logic [8:0] {
    ST_READ = 9'h001, ST_WAIT = 9'h002, ST_PLOAD = 9'h004,
    ST_PBUSY = 9'h008, ST_ECONF = 9'h010, ST_EBUSY = 9'h020,
    ST_SCONF = 9'h040, ST_STS = 9'h080, ST_PADDR = 9'h100
  } fpm_st_e;
  typedef struct packed {
    fpm_st_e             st;
    logic                we_q;
    logic [PAGE_W-1:0]   cnt;
    logic [PG_NUM_W-1:0] page;
    logic                bad;
    logic [1:0]          poll;
    logic [7:0]          rc;
    logic                start_pgm;
    logic                start_ers;
    logic [7:0]          dout;
    logic                doe;
    logic                lock;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } fpm_top_s;

  fpm_top_s s, next_s;
  logic       wr;
  logic       buf_we;
  logic [7:0] buf_rd;
  logic [PAGE_W-1:0] buf_ridx;
  logic [7:0] mem_rd;
  logic       pg_used;
  logic       core_busy;
  logic       core_done;

  // Write strobe: rising edge of write-enable while chip-enable held
  assign wr = pin_in.we_n && !s.we_q && !pin_in.ce_n;
  assign buf_we = wr && (s.st == ST_PLOAD || s.st == ST_PADDR);

  // Return code for a command error: abnormal-end and command bits set
  function automatic logic [7:0] cmd_err_rc();
    logic [7:0] r;
    r = RC_RESET;
    r[RC_ABN] = 1'b1;
    r[RC_CMD] = 1'b1;
    return r;
  endfunction

  // Command sequencer, pin output and APB slave
  always_comb begin
    next_s = s;
    next_s.we_q = pin_in.we_n;
    next_s.start_pgm = 1'b0;
    next_s.start_ers = 1'b0;
    unique case (s.st)
      ST_READ, ST_WAIT, ST_STS: begin
        if (wr) begin // Same decode in read mode and wait state RULE_20
          next_s.poll = POLL_BUSY; // Polling pair dropped on command RULE_09
          if (pin_in.data != CMD_STS) begin
            next_s.rc = RC_RESET; // RULE_15
          end
          unique case (pin_in.data) // RULE_17
            CMD_READ: next_s.st = ST_READ;
            CMD_PGM: begin
              next_s.st = s.lock ? ST_WAIT : ST_PADDR;
              next_s.cnt = '0;
              if (s.lock) begin
                next_s.rc = cmd_err_rc();
                next_s.poll = POLL_ABN;
              end
            end
            CMD_ERS: next_s.st = ST_ECONF;
            CMD_STS: next_s.st = ST_SCONF;
            default: begin
              next_s.st = ST_WAIT;
              next_s.rc = cmd_err_rc();
              next_s.poll = POLL_ABN;
            end
          endcase
        end
      end
      ST_PADDR: begin
        if (wr) begin // Page address only on the first data cycle RULE_05
          next_s.page = pin_in.addr[ADDR_W-1:PAGE_W];
          next_s.bad = |pin_in.addr[PAGE_W-1:0];
          next_s.cnt = PAGE_W'(1);
          next_s.st = ST_PLOAD;
        end
      end
      ST_PLOAD: begin
        if (wr) begin // Index counts bytes, address pins ignored RULE_05
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == PAGE_W'(PAGE_BYTES - 1)) begin // 128th byte RULE_01 RULE_18
            if (pg_used) begin
              next_s.st = ST_WAIT;
              next_s.rc[RC_ABN] = 1'b1;
              next_s.rc[RC_PGM] = 1'b1;
              next_s.rc[RC_OVER] = 1'b1;
              next_s.rc[RC_ADDR] = s.bad;
              next_s.poll = POLL_ABN;
            end else begin
              next_s.st = ST_PBUSY;
              next_s.start_pgm = 1'b1;
            end
          end
        end
      end
      ST_PBUSY: begin
        if (core_done) begin
          next_s.st = ST_WAIT;
          next_s.poll = s.bad ? POLL_ABN : POLL_OK; // RULE_08 RULE_19
          next_s.rc[RC_ABN] = s.bad; // Write done, error still flagged RULE_04
          next_s.rc[RC_PGM] = s.bad;
          next_s.rc[RC_ADDR] = s.bad; // RULE_16
        end
      end
      ST_ECONF: begin
        if (wr) begin
          if (pin_in.data == CMD_ERS && !s.lock) begin
            next_s.st = ST_EBUSY;
            next_s.start_ers = 1'b1; // RULE_10
          end else begin
            next_s.st = ST_WAIT;
            next_s.rc = cmd_err_rc();
            next_s.poll = POLL_ABN;
          end
        end
      end
      ST_EBUSY: begin
        if (core_done) begin
          next_s.st = ST_WAIT;
          next_s.poll = POLL_OK; // RULE_19
        end
      end
      ST_SCONF: begin
        if (wr) begin
          if (pin_in.data == CMD_STS) begin
            next_s.st = ST_STS; // RULE_14
          end else begin
            next_s.st = ST_WAIT;
            next_s.rc = cmd_err_rc();
            next_s.poll = POLL_ABN;
          end
        end
      end
    endcase

    // Pin output picks array, polling pair or return code
    next_s.doe = !pin_in.ce_n && !pin_in.oe_n; // RULE_21
    if (s.st == ST_READ) begin
      next_s.dout = mem_rd;
    end else if (s.st == ST_STS) begin
      next_s.dout = s.rc; // RULE_14
    end else if (s.st == ST_WAIT) begin
      next_s.dout = {s.poll, 6'h00}; // RULE_09
    end else begin
      next_s.dout = 8'h00; // Still running RULE_19
    end

    // APB: one wait state, answer registered
    next_s.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready) begin
      next_s.prdata = 32'h0;
      next_s.pslverr = 1'b0;
      if (paddr == REG_CTRL) begin
        next_s.prdata[CTRL_LOCK] = s.lock;
      end else if (paddr == REG_STAT) begin
        next_s.prdata[7:0] = s.rc;
        next_s.prdata[STAT_POLL+:2] = s.poll;
        next_s.prdata[STAT_BUSY] = core_busy;
        next_s.prdata[STAT_ST+:9] = s.st;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end
    if (psel && penable && s.pready && pwrite && paddr == REG_CTRL) begin
      next_s.lock = pwdata[CTRL_LOCK];
    end
  end

  // State register; power-on lands in memory read mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: ST_READ, we_q: 1'b1, cnt: '0, page: '0, bad: 1'b0, // RULE_20
             poll: POLL_BUSY, rc: RC_RESET, start_pgm: 1'b0, start_ers: 1'b0,
             dout: 8'h00, doe: 1'b0, lock: CTRL_LOCK_RST, prdata: 32'h0,
             pready: 1'b0, pslverr: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  fpm_page_buf #(.DEPTH(PAGE_BYTES), .W(8)) u_buf (
    .pclk    (pclk),
    .wr_en   (buf_we),
    .wr_idx  (s.st == ST_PADDR ? PAGE_W'(0) : s.cnt),
    .wr_data (pin_in.data),
    .rd_idx  (buf_ridx),
    .rd_data (buf_rd)
  );

  fpm_flash_core #(.WRITE_CYC_P(WRITE_CYC_P), .ERASE_CYC_P(ERASE_CYC_P)) u_core (
    .pclk      (pclk),
    .presetn   (presetn),
    .start_pgm (s.start_pgm),
    .start_ers (s.start_ers),
    .pg        (s.page),
    .buf_data  (buf_rd),
    .buf_idx   (buf_ridx),
    .rd_addr   (pin_in.addr),
    .rd_data   (mem_rd),
    .pg_used   (pg_used),
    .busy      (core_busy),
    .done      (core_done)
  );

  assign data_out = s.dout;
  assign data_oe  = s.doe;
  assign prdata   = s.prdata;
  assign pready   = s.pready;
  assign pslverr  = s.pslverr;

  // Checks on the sequencer and pins
  a_drive_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
    data_oe |-> $past(!pin_in.ce_n && !pin_in.oe_n))
    else $error("data pins driven without chip and output enable");
  a_busy_low: assert property (@(posedge pclk) disable iff (!presetn) // RULE_19
    s.st == ST_PBUSY |=> !data_out[7])
    else $error("busy flag not shown on data_pin_seven");
  a_page_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    (s.st == ST_PLOAD && wr && s.cnt == PAGE_W'(PAGE_BYTES - 1) && !pg_used)
    |=> s.start_pgm ##1 !s.start_pgm && s.st == ST_PBUSY)
    else $error("page program not started after 128th byte");
  a_cmd_pgm: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
    (s.st == ST_READ && wr && pin_in.data == CMD_PGM && !s.lock) |=> s.st == ST_PADDR)
    else $error("program command not accepted in read mode");
  a_ers_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    (s.st == ST_ECONF && wr && pin_in.data == CMD_ERS && !s.lock)
    |=> s.start_ers ##1 core_busy)
    else $error("erase did not start on second erase byte");
  a_rc_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    (s.st == ST_STS && !wr) |=> $stable(s.rc))
    else $error("return code changed without a command write");
  a_bad_addr: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    (s.st == ST_PBUSY && core_done && s.bad) |=> s.rc[RC_ADDR] && s.poll == POLL_ABN)
    else $error("misaligned page not reported");
  a_poll_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    (s.st == ST_WAIT && !wr) |=> $stable(s.poll) && s.st == ST_WAIT)
    else $error("polling pair lost before next command");
  a_ok_poll: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    (s.st == ST_PBUSY && core_done && !s.bad) |=> s.poll == POLL_OK)
    else $error("normal end not shown on data_pin_six");
  a_apb_ans: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access");

  c_prog_done: cover property (@(posedge pclk) disable iff (!presetn)
    s.st == ST_PBUSY ##1 s.st == ST_WAIT);
  c_erase_done: cover property (@(posedge pclk) disable iff (!presetn)
    s.st == ST_EBUSY ##1 s.st == ST_WAIT);
  c_sts_read: cover property (@(posedge pclk) disable iff (!presetn)
    s.st == ST_STS && data_oe);
  c_cmd_err: cover property (@(posedge pclk) disable iff (!presetn)
    wr ##1 s.rc[RC_CMD]);
endmodule // fpm_port

/* File: tb/fpm_prog_model.sv */
// Programmer model driving the flash port pins
`timescale 1ns/1ps
module fpm_prog_model import fpm_pkg::*; (
  input  wire logic       pclk,
  output fpm_pin_in_s     pin_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  localparam int STS_WAIT = 20 * (CLK_HZ / 1_000_000);
  logic [7:0] rd_d;
  logic       rd_oe;

  // Idle pins: deselected, write strobe high
  initial pin_in = '{1'b1, 1'b1, 1'b1, 15'h0000, 8'h5a};

  // One write cycle; released data lines then show the inverse byte
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge pclk);
    pin_in <= '{1'b0, 1'b1, 1'b0, a, d};
    @(posedge pclk);
    pin_in.we_n <= 1'b1;
    @(posedge pclk);
    pin_in.ce_n <= 1'b1;
    pin_in.data <= ~d;
  endtask

  // Read with both enables low, sampled once the device pipeline settles
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge pclk);
    pin_in.ce_n <= 1'b0;
    pin_in.oe_n <= 1'b0;
    pin_in.addr <= a;
    repeat (4) @(posedge pclk);
    #1;
    rd_d = data_out;
    rd_oe = data_oe;
    @(posedge pclk);
    pin_in.ce_n <= 1'b1;
    pin_in.oe_n <= 1'b1;
  endtask

  // Erase and status read repeat their command byte
  task automatic cmd2(input logic [7:0] c);
    wr('0, c);
    wr('0, c);
  endtask

  // Status read: command pair, settle time, then the code
  task automatic status();
    cmd2(CMD_STS);
    repeat (STS_WAIT) @(posedge pclk);
    rd('0);
  endtask

  // Page program: command, then the whole page at one address
  task automatic page_write(input logic [ADDR_W-1:0] a, input logic [7:0] pg[PAGE_BYTES]);
    wr('0, CMD_PGM);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      wr(a, pg[i]);
    end
  endtask
endmodule // fpm_prog_model

/* File: tb/tb_top.sv */
// Self-checking bench for the programmer-mode flash port
`timescale 1ns/1ps
module tb_top import fpm_pkg::*; ();
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  fpm_pin_in_s       pin_in;
  logic [7:0]        data_out;
  logic              data_oe;
  int                miscompares;
  int                cmp_count;
  logic [31:0]       ard;
  logic              aerr;
  logic [7:0]        pg [PAGE_BYTES];
  logic [7:0]        ref_mem [2**ADDR_W];
  logic [ADDR_W-1:0] pa;
  logic [ADDR_W-1:0] pb;
  localparam int     POLL_START = 8; // Polling start wait, scaled like the busy times

  fpm_port #(.WRITE_CYC_P(8), .ERASE_CYC_P(8)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .data_out(data_out), .data_oe(data_oe));

  fpm_prog_model prog_u (.pclk(pclk), .pin_in(pin_in), .data_out(data_out), .data_oe(data_oe));

  // 40 MHz clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ard = prdata;
    aerr = pslverr;
    if (n == 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Poll the status pins until the run ends; only reads meanwhile
  task automatic poll(input logic [7:0] exp);
    int n;
    n = 0;
    repeat (POLL_START) @(posedge pclk);
    do begin
      prog_u.rd('0);
      n++;
    end while (prog_u.rd_d[7] !== 1'b1 && n < 20000);
    check(prog_u.rd_d, exp);
  endtask

  // Memory read of sixteen bytes of a page, first and last included
  task automatic mcheck(input logic [ADDR_W-1:0] a);
    prog_u.wr('0, CMD_READ);
    for (int i = 0; i < 16; i++) begin
      prog_u.rd(a + ADDR_W'(i * 8 + i % 8));
      check(prog_u.rd_d, ref_mem[a + ADDR_W'(i * 8 + i % 8)]);
      check(prog_u.rd_oe, 1'b1);
    end
    @(posedge pclk);
    #1;
    check(data_oe, 1'b0);
  endtask

  // Random page with the tail padded
  task automatic mkpg(input int k);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      pg[i] = i < k ? 8'($urandom) : FILL_BYTE;
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(25 * 90_000);
    miscompares++;
    final_report();
  end

  initial begin
    miscompares = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(37));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state, register access kinds, unmapped address
    check(data_oe, 1'b0);
    apb(1'b1, REG_STAT, $urandom);
    check(aerr, 1'b0);
    apb(1'b0, REG_STAT, 32'h0);
    check(ard[10:0], 11'h000);
    apb(1'b0, REG_CTRL, 32'h0);
    check(ard, 32'h0);
    apb(1'b0, {6'($urandom_range(62, 2)), 2'b00}, 32'h0);
    check({aerr, ard[30:0]}, 32'h8000_0000);
    // Whole-array erase; busy times and the polling start wait are scaled down
    prog_u.cmd2(CMD_ERS);
    repeat (POLL_START) @(posedge pclk);
    prog_u.rd('0);
    check(prog_u.rd_d, {POLL_BUSY, 6'h00});
    apb(1'b0, REG_STAT, 32'h0);
    check(ard[10:8], 3'b100);
    poll({POLL_OK, 6'h00});
    apb(1'b0, REG_STAT, 32'h0);
    check(ard[9:8], POLL_OK);
    foreach (ref_mem[i]) ref_mem[i] = FILL_BYTE;
    mcheck(15'($urandom));
    // Aligned program of a short page
    pa = {8'($urandom), 7'h00};
    mkpg(1 + $urandom_range(126));
    prog_u.page_write(pa, pg);
    repeat (POLL_START) @(posedge pclk);
    prog_u.rd('0);
    check(prog_u.rd_d, 8'h00);
    poll(8'hc0);
    prog_u.rd('0);
    check(prog_u.rd_d, 8'hc0);
    for (int i = 0; i < PAGE_BYTES; i++) ref_mem[pa + ADDR_W'(i)] = pg[i];
    prog_u.status();
    check(prog_u.rd_d, 8'h00);
    mcheck(pa);
    // Second program of a used page is refused
    mkpg(PAGE_BYTES);
    prog_u.page_write(pa, pg);
    poll(8'h80);
    prog_u.status();
    check(prog_u.rd_d, 8'ha2);
    prog_u.status();
    check(prog_u.rd_d, 8'ha2);
    mcheck(pa);
    // Misaligned page address still writes but flags an error
    pb = {pa[14:7] + 8'h01, 7'h05};
    prog_u.page_write(pb, pg);
    poll(8'h80);
    prog_u.status();
    check(prog_u.rd_d, 8'ha1);
    for (int i = 0; i < PAGE_BYTES; i++) ref_mem[{pb[14:7], 7'(i)}] = pg[i];
    mcheck({pb[14:7], 7'h00});
    // Unknown byte and broken erase pair give a command error
    prog_u.wr('0, 8'h55);
    prog_u.status();
    check(prog_u.rd_d, 8'hc0);
    prog_u.wr('0, CMD_READ);
    prog_u.status();
    check(prog_u.rd_d, 8'h00);
    prog_u.wr('0, CMD_ERS);
    prog_u.wr('0, 8'h55);
    prog_u.status();
    check(prog_u.rd_d, 8'hc0);
    // Lock turns a program command into a command error
    apb(1'b1, REG_CTRL, $urandom | 32'h1);
    apb(1'b0, REG_CTRL, 32'h0);
    check(ard, 32'h1);
    prog_u.wr('0, CMD_PGM);
    apb(1'b0, REG_STAT, 32'h0);
    check(ard[9:0], {POLL_ABN, 8'hc0});
    // Lock also refuses the erase pair; no erase may start
    prog_u.cmd2(CMD_ERS);
    prog_u.rd('0);
    check(prog_u.rd_d, 8'h80);
    prog_u.status();
    check(prog_u.rd_d, 8'hc0);
    // Mid-run reset: codes and lock clear, array kept, read mode again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0);
    check(ard[9:0], 10'h000);
    apb(1'b0, REG_CTRL, 32'h0);
    check(ard, 32'h0);
    prog_u.rd(pa);
    check(prog_u.rd_d, ref_mem[pa]);
    apb(1'b1, REG_CTRL, 32'h0);
    final_report();
  end
endmodule // tb_top
